// ==== hw/ppc_pkg.sv ====
// Package for the port pin control block: register map, reset values, carriers.
// Assumes one 8-bit port reached over APB with 32-bit data, one word per register.
package ppc_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] PPC_OFF_DATA     = 8'h00;
    localparam logic [7:0] PPC_OFF_OUT_EN   = 8'h04;
    localparam logic [7:0] PPC_OFF_FUNC_SEL = 8'h08;
    localparam logic [7:0] PPC_OFF_OPEN_DRN = 8'h28;
    localparam logic [7:0] PPC_OFF_PULL_HI  = 8'h2c;
    localparam logic [7:0] PPC_OFF_PULL_LO  = 8'h30;
    localparam logic [7:0] PPC_OFF_IN_EN    = 8'h38;
    localparam logic [7:0] PPC_OFF_STATUS   = 8'h3c;

    localparam int PPC_WIDTH = 8;

    // ==========================================================
    // Pin roles inside the port
    localparam int PPC_BIT_DBG_DATA  = 0;
    localparam int PPC_BIT_DBG_CLK   = 1;
    localparam int PPC_BIT_DRAIN     = 7;
    localparam logic [7:0] PPC_IRQ_PIN_MASK = 8'h3c;

    // ==========================================================
    // Reset values
    localparam logic [7:0] PPC_RST_DATA     = 8'h00;
    localparam logic [7:0] PPC_RST_OUT_EN   = 8'h01;
    localparam logic [7:0] PPC_RST_FUNC_SEL = 8'h03;
    localparam logic [7:0] PPC_RST_OPEN_DRN = 8'h00;
    localparam logic [7:0] PPC_RST_PULL_HI  = 8'h01;
    localparam logic [7:0] PPC_RST_PULL_LO  = 8'h02;
    localparam logic [7:0] PPC_RST_IN_EN    = 8'h00;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [7:0] out_val;
        logic [7:0] out_en;
        logic [7:0] in_en;
        logic [7:0] pull_hi;
        logic [7:0] pull_lo;
    } ppc_pad_s;

    typedef struct packed {
        logic [7:0] func_sel;
        logic [7:0] out_en;
        logic [7:0] in_en;
        logic [7:0] open_drn;
        logic [7:0] port_val;
        logic [7:0] pull_hi;
        logic [7:0] pull_lo;
    } ppc_cfg_s;

    typedef struct packed {
        logic [7:0] periph_out;
        logic [7:0] periph_oe;
        logic       dbg_data_valid;
        logic       stop_mode;
        logic       drive_keep;
    } ppc_side_s;

endpackage : ppc_pkg

// ==== hw/ppc_pad_gate.sv ====
// Combinational pad gating for one port: function mux, open drain, STOP gating.
// Assumes configuration and stop inputs are already synchronous to pclk.
`timescale 1ns/1ps

module ppc_pad_gate
    import ppc_pkg::*;
(
    input  wire ppc_cfg_s  cfg,
    input  wire ppc_side_s side,
    output ppc_pad_s       pad
);

    logic [7:0] drv_val;
    logic [7:0] drv_oe;
    logic [7:0] in_ok;

    // ==========================================================
    // Per-pin gating
    genvar i;
    generate
        for (i = 0; i < PPC_WIDTH; i++) begin : g_pin
            localparam bit IS_IRQ = PPC_IRQ_PIN_MASK[i];
            localparam bit IS_DBG = (i == PPC_BIT_DBG_DATA);
            localparam bit IS_DRN = (i == PPC_BIT_DRAIN);
            logic val;
            logic oe_cfg;
            logic gated_oe;
            logic gated_ie;
            always_comb begin
                // Peripheral owns the level when selected
                val = cfg.func_sel[i] ? side.periph_out[i] : cfg.port_val[i];
                oe_cfg = cfg.out_en[i] & (cfg.func_sel[i] ? side.periph_oe[i] : 1'b1);
                gated_oe = oe_cfg;
                gated_ie = cfg.in_en[i];
                if (side.stop_mode) begin
                    if (!side.drive_keep) begin
                        gated_oe = 1'b0;
                        gated_ie = 1'b0;
                    end
                    if (IS_IRQ && cfg.func_sel[i] && cfg.in_en[i]) begin
                        gated_ie = 1'b1;
                    end
                    if (IS_DBG && cfg.func_sel[i] && cfg.out_en[i]) begin
                        gated_oe = side.dbg_data_valid;
                    end
                end
                // Open drain: a high level releases the pin instead of driving it
                if (cfg.open_drn[i] || IS_DRN) begin
                    drv_oe[i] = gated_oe & ~val;
                end else begin
                    drv_oe[i] = gated_oe;
                end
                drv_val[i] = IS_DRN ? 1'b0 : val;
                in_ok[i] = gated_ie;
            end
            // Pulls are independent of data and direction; none on the drain pin
            assign pad.pull_hi[i] = IS_DRN ? 1'b0 : cfg.pull_hi[i];
            assign pad.pull_lo[i] = IS_DRN ? 1'b0 : cfg.pull_lo[i];
        end
    endgenerate

    assign pad.out_val = drv_val & drv_oe;
    assign pad.out_en  = drv_oe;
    assign pad.in_en   = in_ok;

endmodule : ppc_pad_gate

// ==== hw/ppc_port.sv ====
// Port pin control top: APB register file, pin input sync and registered pad drive.
// Assumes an APB master on pclk; pins are asynchronous and synchronised here.
`timescale 1ns/1ps

// Notes on behaviour
// - The data register reads back the latch on output pins and the pin level on the rest, and holds the value the pin drives as output.
// - Output enable gates the output buffer and a separate input enable gates the input buffer.
// - A function select bit of 1 routes the pin to its peripheral, 0 keeps port use.
// - With the open-drain bit set the pin never drives high but may still drive low.
// - Pull-up and pull-down are each switched by their own bit independent of data and direction.
// - Input enables reset to disabled so that no input current flows until software sets them.
// - In STOP with drive-keep at 1 the buffers follow their enable bits as in normal running, except the debug data pin.
// - In STOP with drive-keep at 0 ordinary pins have both buffers forced off.
// - A debug data pin in debug function with output enabled drives in STOP only while data is valid.
// - Interrupt pins in interrupt function with input enabled keep their input alive in STOP.
// - The consumer control pin is a true open drain with no pull, driving only low.
// - After reset the debug data and debug clock pins are assigned to the debug function.
module ppc_port
    import ppc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        stop_mode,
    input  wire logic        drive_keep,
    input  wire logic        dbg_data_valid,
    input  wire logic [7:0]  periph_out,
    input  wire logic [7:0]  periph_oe,
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe,
    output logic      [7:0]  pin_in_en,
    output logic      [7:0]  pull_high,
    output logic      [7:0]  pull_low,
    output logic      [7:0]  periph_in
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0]  port_data;
        logic [7:0]  out_en;
        logic [7:0]  func_sel;
        logic [7:0]  open_drn;
        logic [7:0]  pull_hi;
        logic [7:0]  pull_lo;
        logic [7:0]  in_en;
        logic [7:0]  sync1;
        logic [7:0]  sync2;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        ppc_pad_s    pad;
        logic [7:0]  pin_seen;
        logic [7:0]  periph_seen;
    } ppc_state_s;

    ppc_state_s state_reg;
    ppc_state_s state_next;
    ppc_cfg_s   cfg;
    ppc_side_s  side;
    ppc_pad_s   pad_comb;

    // ==========================================================
    // Pad gating
    always_comb begin
        cfg.func_sel = state_reg.func_sel;
        cfg.out_en   = state_reg.out_en;
        cfg.in_en    = state_reg.in_en;
        cfg.open_drn = state_reg.open_drn;
        cfg.port_val = state_reg.port_data;
        cfg.pull_hi  = state_reg.pull_hi;
        cfg.pull_lo  = state_reg.pull_lo;
        side.periph_out     = periph_out;
        side.periph_oe      = periph_oe;
        side.dbg_data_valid = dbg_data_valid;
        side.stop_mode      = stop_mode;
        side.drive_keep     = drive_keep;
    end

    ppc_pad_gate u_gate (
        .cfg  (cfg),
        .side (side),
        .pad  (pad_comb)
    );

    // ==========================================================
    // Next state
    logic       setup;
    logic       access;
    logic [7:0] rd_byte;
    logic       hit;

    always_comb begin
        state_next = state_reg;
        setup  = psel & ~penable;
        access = psel & penable & state_reg.ready;
        rd_byte = 8'h00;
        hit = 1'b1;

        // Pin levels cross into pclk via two flops before anyone reads them
        state_next.sync1 = pin_in;
        state_next.sync2 = state_reg.sync1;
        // Only enabled inputs reach the core; blocked inputs read as 0
        state_next.pin_seen = state_reg.sync2 & state_reg.pad.in_en;
        // Peripheral sees the input only where selected and enabled
        state_next.periph_seen = state_reg.sync2 & state_reg.pad.in_en & state_reg.func_sel;
        state_next.pad = pad_comb;

        case (paddr)
            PPC_OFF_DATA: begin
                // Output pins read back the latch, the rest read the pin
                rd_byte = (state_reg.port_data & state_reg.out_en)
                        | (state_reg.pin_seen & ~state_reg.out_en);
            end
            PPC_OFF_OUT_EN:   rd_byte = state_reg.out_en;
            PPC_OFF_FUNC_SEL: rd_byte = state_reg.func_sel;
            PPC_OFF_OPEN_DRN: rd_byte = state_reg.open_drn;
            PPC_OFF_PULL_HI:  rd_byte = state_reg.pull_hi;
            PPC_OFF_PULL_LO:  rd_byte = state_reg.pull_lo;
            PPC_OFF_IN_EN:    rd_byte = state_reg.in_en;
            PPC_OFF_STATUS:   rd_byte = state_reg.pad.out_en;
            default:          hit = 1'b0;
        endcase

        // No wait state: ready rises in the first access cycle, answer at the next edge
        state_next.ready = setup;
        if (setup) begin
            state_next.rdata  = 32'h0000_0000;
            state_next.slverr = 1'b0;
            if (!pwrite) begin
                state_next.rdata = {24'h00_0000, rd_byte};
            end
            state_next.slverr = ~hit;
        end
        if (access) begin
            state_next.ready  = 1'b0;
            state_next.slverr = 1'b0;
            if (pwrite && hit) begin
                case (paddr)
                    PPC_OFF_DATA:     state_next.port_data = pwdata[7:0];
                    PPC_OFF_OUT_EN:   state_next.out_en    = pwdata[7:0];
                    PPC_OFF_FUNC_SEL: state_next.func_sel  = pwdata[7:0];
                    PPC_OFF_OPEN_DRN: state_next.open_drn  = pwdata[7:0];
                    PPC_OFF_PULL_HI:  state_next.pull_hi   = pwdata[7:0];
                    PPC_OFF_PULL_LO:  state_next.pull_lo   = pwdata[7:0];
                    PPC_OFF_IN_EN:    state_next.in_en     = pwdata[7:0];
                    default:          state_next.port_data = state_reg.port_data;
                endcase
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg           <= '0;
            state_reg.port_data <= PPC_RST_DATA;
            state_reg.out_en    <= PPC_RST_OUT_EN;
            state_reg.func_sel  <= PPC_RST_FUNC_SEL;
            state_reg.open_drn  <= PPC_RST_OPEN_DRN;
            state_reg.pull_hi   <= PPC_RST_PULL_HI;
            state_reg.pull_lo   <= PPC_RST_PULL_LO;
            state_reg.in_en     <= PPC_RST_IN_EN;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Outputs, all straight from flops
    assign prdata    = state_reg.rdata;
    assign pready    = state_reg.ready;
    assign pslverr   = state_reg.slverr;
    assign pin_out   = state_reg.pad.out_val;
    assign pin_oe    = state_reg.pad.out_en;
    assign pin_in_en = state_reg.pad.in_en;
    assign pull_high = state_reg.pad.pull_hi;
    assign pull_low  = state_reg.pad.pull_lo;
    assign periph_in = state_reg.periph_seen;

endmodule : ppc_port

// ==== sim/ppc_port_chk.sv ====
// Checker for ppc_port: APB answer timing and pad gating relations.
// Assumes it is bound to ppc_port and sees only that module's ports.
`timescale 1ns/1ps
module ppc_port_chk
    import ppc_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic       pready,
    input wire logic       stop_mode,
    input wire logic       drive_keep,
    input wire logic       dbg_data_valid,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_in_en,
    input wire logic [7:0] pull_high,
    input wire logic [7:0] pull_low
);
    // ==========================================================
    // Properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s; psel && !penable; endsequence
    sequence stop_off_s; stop_mode && !drive_keep; endsequence
    access_ready_a: assert property (setup_s |=> pready) else $error("ready late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
    stop_gate_a: assert property (stop_off_s |=> !pin_oe[7:1]
        && !(pin_in_en & ~PPC_IRQ_PIN_MASK)) else $error("stop gating missing");
    debug_valid_a: assert property (stop_off_s ##0 !dbg_data_valid |=> !pin_oe[0])
        else $error("debug pin drives without data");
    drain_low_a: assert property (pin_oe[PPC_BIT_DRAIN] |-> !pin_out[PPC_BIT_DRAIN])
        else $error("drain pin drives high");
    drain_nopull_a: assert property (!pull_high[PPC_BIT_DRAIN] && !pull_low[PPC_BIT_DRAIN])
        else $error("drain pin pulled");
    drive_only_a: assert property (!(pin_out & ~pin_oe)) else $error("value on free pin");
    pull_write_a: assert property ($changed({pull_high, pull_low}) && $past(presetn, 2)
        |-> $past(pwrite && pready, 2)) else $error("pull changed without write");
endmodule : ppc_port_chk

bind ppc_port ppc_port_chk ppc_port_chk_inst (.*);

// ==== sim/ppc_board.sv ====
// Board model on the port pins: resolves each pin from pad drive, board drive and pulls.
// Assumes ppc_port pad outputs; a pin nobody holds toggles, so it never reads stable.
`timescale 1ns/1ps
module ppc_board
    import ppc_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pull_high,
    input  wire logic [7:0] pull_low,
    input  wire logic [7:0] board_val,
    input  wire logic [7:0] board_en,
    output logic      [7:0] pin_in
);
    // ==========================================================
    // Pin level: pad wins, then board, then pulls, else floating
    logic [7:0] float_q = 8'h55;
    always @(posedge pclk) float_q <= ~float_q;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_en & board_val)
                  | (~pin_oe & ~board_en & (pull_high | (~pull_low & float_q)));
endmodule : ppc_board

// ==== sim/ppc_port_test.sv ====
// Testbench for ppc_port: APB registers, pad drive, function routing, STOP gating.
// Assumes ppc_board on the pins and ppc_port_chk bound to the design.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module ppc_port_test;
    import ppc_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        stop_mode = 1'b0, drive_keep = 1'b0, dbg_data_valid = 1'b0, pready, pslverr, rerr;
    logic [7:0]  paddr = 8'h00, periph_out = 8'h00, periph_oe = 8'hff, board_val = 8'h00;
    logic [7:0]  board_en = 8'h00, pin_in, pin_out, pin_oe, pin_in_en, pull_high, pull_low, periph_in;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    int          n_checks = 0, n_mismatch = 0;
    always #12.5 pclk = ~pclk;
    ppc_port  ppc_port_inst (.*);
    ppc_board ppc_board_inst (.*);
    // ==========================================================
    // Bus helpers: the request stands until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (k = 0; k < 99 && pready !== 1'b1; k++) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask : apb
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(nm, x, rdat)
    endtask : rchk
    // Pads are registered and inputs pass two sync flops, so settle before looking
    task automatic cfg(input logic [7:0] fs, oe, ie, od, dat);
        apb(1'b1, PPC_OFF_FUNC_SEL, {24'h0, fs});
        apb(1'b1, PPC_OFF_OUT_EN, {24'h0, oe});
        apb(1'b1, PPC_OFF_IN_EN, {24'h0, ie});
        apb(1'b1, PPC_OFF_OPEN_DRN, {24'h0, od});
        apb(1'b1, PPC_OFF_DATA, {24'h0, dat});
        repeat (6) @(posedge pclk);
    endtask : cfg
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        logic [7:0] offs [6] = '{PPC_OFF_OUT_EN, PPC_OFF_FUNC_SEL, PPC_OFF_OPEN_DRN,
                                 PPC_OFF_PULL_HI, PPC_OFF_PULL_LO, PPC_OFF_IN_EN};
        `CHK("pads", 40'h0100010200, {pin_oe, pin_in_en, pull_high, pull_low, pin_out})
        rchk("func", PPC_OFF_FUNC_SEL, 32'h3);
        rchk("unmapped", 8'h40, 32'h0);
        `CHK("error", 1'b1, rerr)
        foreach (offs[i]) begin
            apb(1'b1, offs[i], 32'hffff_ff5a);
            rchk("readback", offs[i], 32'h5a);
        end
        $display("reset and register test done");
    endtask : t_reset
    task automatic t_port();
        {board_en, board_val} <= 16'hf0a0;
        apb(1'b1, PPC_OFF_PULL_HI, 32'h30);
        apb(1'b1, PPC_OFF_PULL_LO, 32'hc0);
        cfg(8'h00, 8'h0f, 8'hff, 8'h00, 8'h05);
        `CHK("drive", 16'h0f05, {pin_oe, pin_out})
        `CHK("pulls", 16'h3040, {pull_high, pull_low})
        rchk("data", PPC_OFF_DATA, 32'ha5);
        cfg(8'h00, 8'h0f, 8'h00, 8'h04, 8'h05);
        `CHK("drain", 8'h0b, pin_oe)
        rchk("data no input", PPC_OFF_DATA, 32'h05);
        $display("port drive test done");
    endtask : t_port
    task automatic t_func();
        {periph_out, periph_oe, board_en, board_val} <= 32'h141c_2020;
        cfg(8'h3c, 8'h3c, 8'hff, 8'h00, 8'h00);
        `CHK("periph drive", 16'h1c14, {pin_oe, pin_out})
        `CHK("periph input", 8'h34, periph_in)
        $display("function test done");
    endtask : t_func
    task automatic t_stop();
        logic [18:0] tbl [5] = '{{3'b001, 16'hffff}, {3'b111, 16'hffff}, {3'b101, 16'h013c},
                                 {3'b100, 16'h003c}, {3'b110, 16'hfeff}};
        {periph_out, periph_oe, board_en} <= 24'h00ff00;
        cfg(8'h3d, 8'hff, 8'hff, 8'h00, 8'h00);
        foreach (tbl[i]) begin
            {stop_mode, drive_keep, dbg_data_valid} <= tbl[i][18:16];
            repeat (3) @(posedge pclk);
            `CHK("stop", tbl[i][15:0], {pin_oe, pin_in_en})
        end
        stop_mode <= 1'b0;
        $display("stop gating test done");
    endtask : t_stop
    initial begin
        repeat (3000) @(posedge pclk);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        t_reset();
        t_port();
        t_func();
        t_stop();
        report_and_stop();
    end
endmodule : ppc_port_test
